// [core/mmg_config.sv]
// mode and channel gain configuration registers with decoded outputs
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: mode bits 0-2 pick phases for pulse one
// R2: mode bits 3-5 pick phases for pulse two
// R3: mode bits 6-8 pick phases for pulse three
// R4: angle field selects pair type or none
// R5: bit 11 substitutes nominal voltage on phase A
// R6: bit 12 substitutes nominal voltage on phase B
// R7: bit 13 substitutes nominal voltage on phase C
// R8: bit 14 selects 50/60 Hz, fundamental variant
// R9: mode bit 15 unused, reads zero
// R10: phase current gain 1..16, reserved as unity
// R11: neutral gain same; fixed unity (code zero) without neutral
// R12: phase voltage gain 1..16, reserved as unity
// R13: gain bits 15-9 reserved, read zero
// R14: both registers read/write, reserved writes ignored
module mmg_config #(
    parameter bit HAS_NEUTRAL = 1'b1,
    parameter bit HAS_FUND = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [mmg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] i_nominal_voltage_value,
    input wire logic [15:0] i_rms_volt_a,
    input wire logic [15:0] i_rms_volt_b,
    input wire logic [15:0] i_rms_volt_c,
    output logic [31:0] o_rdata,
    output mmg_pkg::mmg_mode_s o_mode,
    output mmg_pkg::mmg_gain_s o_gain,
    output logic [15:0] o_rms_volt_a,
    output logic [15:0] o_rms_volt_b,
    output logic [15:0] o_rms_volt_c
);

    // timing seen from the bus:
    // - a write is taken at the edge where i_wr is high with a matching
    //   address; the register holds the new word right after that edge
    // - decoded outputs follow one edge later, so a write shows on
    //   o_mode or o_gain one edge after the edge where the strobe was sampled
    // - a read is taken at the edge where i_rd is high; o_rdata holds
    //   the word for exactly the next cycle and is zero otherwise
    // - a read in the cycle right after a write returns the new word
    // - the bus never waits; strobes may follow each other back to back
    // - write data above bit 15 is ignored, as is every reserved bit

    // writable bits of the gain word; neutral field drops out without it
    localparam logic [15:0] GAIN_WMASK = HAS_NEUTRAL ?
        mmg_pkg::CHAN_GAIN_WMASK_N : mmg_pkg::CHAN_GAIN_WMASK_NONEUT;

    // number of gain fields and of phases, each handled by one loop
    localparam int NUM_GAINS = 3;
    localparam int NUM_PHASES = 3;

    // field positions gathered so the per-field loop can index them
    localparam int GAIN_LSB [NUM_GAINS] = '{
        mmg_pkg::PHASE_I_GAIN_LSB,
        mmg_pkg::NEUTRAL_I_GAIN_LSB,
        mmg_pkg::PHASE_V_GAIN_LSB
    };

    // substitution enable positions, phase a first
    localparam int NOM_BIT [NUM_PHASES] = '{
        mmg_pkg::NOM_A_BIT,
        mmg_pkg::NOM_B_BIT,
        mmg_pkg::NOM_C_BIT
    };

    // elaboration checks: refuse variants the logic cannot serve
    // the fundamental-only option exists only beside the neutral channel
    if (HAS_FUND && !HAS_NEUTRAL) begin : g_bad_variant
        $error("mmg_config: fundamental variant requires neutral");
    end

    // both register addresses must fit the byte address bus
    if (mmg_pkg::ADDR_W != 18) begin : g_bad_addr
        $error("mmg_config: address bus must be 18 bits wide");
    end

    // the one-hot angle output has a bit for each of four codes
    if ($bits(mmg_pkg::mmg_angle_e) != 2) begin : g_bad_angle
        $error("mmg_config: angle code must be two bits");
    end

    // register storage
    logic [15:0] mode_q;
    logic [15:0] mode_d;
    logic [15:0] gain_q;
    logic [15:0] gain_d;

    // bus decode
    logic mode_sel;
    logic gain_sel;
    logic mode_we;
    logic gain_we;
    logic mode_re;
    logic gain_re;
    logic [31:0] rdata_d;

    // decoded mode fields ahead of the output flops
    mmg_pkg::mmg_angle_e angle_code;
    logic [3:0] angle_onehot_d;
    logic [2:0] nom_use_d;
    logic freq_sel_d;

    // output flops of the mode decode, one per concern
    logic [2:0] pulse_one_q;
    logic [2:0] pulse_two_q;
    logic [2:0] pulse_three_q;
    logic [3:0] angle_onehot_q;
    logic [2:0] nom_use_q;
    logic freq_sel_q;

    // per-field and per-phase results of the generate loops
    logic [2:0] gain_code [NUM_GAINS];
    logic [4:0] gain_lin [NUM_GAINS];
    logic [15:0] rms_in [NUM_PHASES];
    logic [15:0] rms_d [NUM_PHASES];

    // address match; the full byte address is compared, so the low two
    // bits must be zero and a misaligned access hits nothing
    assign mode_sel = (i_addr == mmg_pkg::COMP_MODE_ADDR);
    assign gain_sel = (i_addr == mmg_pkg::CHAN_GAIN_ADDR);

    // strobes qualified by the address match
    assign mode_we = i_wr & mode_sel;
    assign gain_we = i_wr & gain_sel;
    assign mode_re = i_rd & mode_sel;
    assign gain_re = i_rd & gain_sel;

    // next mode value; bit 15 masked off so it always reads zero
    always_comb begin
        mode_d = mode_q;
        if (mode_we) begin
            mode_d = i_wdata[15:0] & mmg_pkg::COMP_MODE_WMASK; // R14 R9
        end
    end

    // mode register; resets to all phases on every pulse output
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q <= mmg_pkg::COMP_MODE_RST; // R1 R2 R3 R9
        end else begin
            mode_q <= mode_d;
        end
    end

    // next gain value; reserved bits and absent neutral field kept zero
    always_comb begin
        gain_d = gain_q;
        if (gain_we) begin
            gain_d = i_wdata[15:0] & GAIN_WMASK; // R14 R13 R11
        end
    end

    // gain register; unity on every channel out of reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gain_q <= mmg_pkg::CHAN_GAIN_RST; // R13
        end else begin
            gain_q <= gain_d;
        end
    end

    // read mux; idle cycles and unmapped reads return zero so a stale
    // word never lingers on the bus
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (mode_re) begin
            rdata_d = {16'h0000, mode_q}; // R14
        end else if (gain_re) begin
            rdata_d = {16'h0000, gain_q}; // R14
        end
    end

    // read data stands for exactly the cycle after the read strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= rdata_d; // R14
        end
    end

    // code to linear gain; reserved codes fall back to unity
    function automatic logic [4:0] gain_of(input logic [2:0] code);
        logic [4:0] g;
        g = 5'h01;
        if (code <= mmg_pkg::GAIN_CODE_MAX) begin
            g = 5'(5'h01 << code);
        end
        return g;
    endfunction

    // one decoder per field: phase current, neutral, phase voltage
    for (genvar k = 0; k < NUM_GAINS; k++) begin : g_gain
        assign gain_code[k] = gain_q[GAIN_LSB[k] +: 3];
        assign gain_lin[k] = gain_of(gain_code[k]); // R10 R11 R12
    end

    // decoded gains registered so outputs come from flops; a gain
    // change reaches the amplifiers one cycle after the register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gain <= '{5'h01, 5'h01, 5'h01};
        end else begin
            o_gain.phase_current_gain <= gain_lin[0]; // R10
            o_gain.neutral_current_gain <= gain_lin[1]; // R11
            o_gain.phase_voltage_gain <= gain_lin[2]; // R12
        end
    end

    // angle field seen as the enum; every two-bit value is legal
    assign angle_code =
        mmg_pkg::mmg_angle_e'(mode_q[mmg_pkg::ANGLE_LSB +: 2]);

    // angle code to one-hot, one bit per measurement kind
    always_comb begin
        angle_onehot_d = 4'h1;
        unique case (angle_code)
            mmg_pkg::MMG_ANGLE_V_TO_I: angle_onehot_d = 4'h1; // R4
            mmg_pkg::MMG_ANGLE_V_TO_V: angle_onehot_d = 4'h2; // R4
            mmg_pkg::MMG_ANGLE_I_TO_I: angle_onehot_d = 4'h4; // R4
            mmg_pkg::MMG_ANGLE_NONE: angle_onehot_d = 4'h8; // R4
        endcase
    end

    // substitution enables in {c,b,a} order as the datapath expects
    assign nom_use_d = {mode_q[mmg_pkg::NOM_C_BIT],
        mode_q[mmg_pkg::NOM_B_BIT], mode_q[mmg_pkg::NOM_A_BIT]}; // R5 R6 R7

    // only the fundamental variant honours the frequency bit; the
    // others hold 50 Hz whatever software wrote
    assign freq_sel_d = HAS_FUND & mode_q[mmg_pkg::FREQ_BIT]; // R8

    // phases summed into the first pulse output
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_one_q <= 3'h7;
        end else begin
            pulse_one_q <= mode_q[mmg_pkg::PULSE_ONE_LSB +: 3]; // R1
        end
    end

    // phases summed into the second pulse output
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_two_q <= 3'h7;
        end else begin
            pulse_two_q <= mode_q[mmg_pkg::PULSE_TWO_LSB +: 3]; // R2
        end
    end

    // phases summed into the third pulse output
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_three_q <= 3'h7;
        end else begin
            pulse_three_q <= mode_q[mmg_pkg::PULSE_THREE_LSB +: 3]; // R3
        end
    end

    // angle measurement kind; the angle engine needs no decoding
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            angle_onehot_q <= 4'h1;
        end else begin
            angle_onehot_q <= angle_onehot_d; // R4
        end
    end

    // nominal voltage substitution enables
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nom_use_q <= 3'h0;
        end else begin
            nom_use_q <= nom_use_d; // R5 R6 R7
        end
    end

    // network frequency for the fundamental filters
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            freq_sel_q <= 1'b0;
        end else begin
            freq_sel_q <= freq_sel_d; // R8
        end
    end

    // the mode struct is only wiring of the flops above
    assign o_mode = '{
        pulse_one_phase_sel: pulse_one_q,
        pulse_two_phase_sel: pulse_two_q,
        pulse_three_phase_sel: pulse_three_q,
        angle_onehot: angle_onehot_q,
        nominal_volt_use: nom_use_q,
        network_freq_select: freq_sel_q
    };

    // measured rms voltages gathered for the per-phase loop
    assign rms_in[0] = i_rms_volt_a;
    assign rms_in[1] = i_rms_volt_b;
    assign rms_in[2] = i_rms_volt_c;

    // per phase: the nominal value replaces the measured rms for every
    // user downstream, apparent power included; substituting here once
    // keeps all users consistent instead of patching each of them
    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_rms
        assign rms_d[p] = mode_q[NOM_BIT[p]] ?
            i_nominal_voltage_value : rms_in[p]; // R5 R6 R7
    end

    // phase a rms voltage as seen by every rms user
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rms_volt_a <= 16'h0000;
        end else begin
            o_rms_volt_a <= rms_d[0]; // R5
        end
    end

    // phase b rms voltage as seen by every rms user
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rms_volt_b <= 16'h0000;
        end else begin
            o_rms_volt_b <= rms_d[1]; // R6
        end
    end

    // phase c rms voltage as seen by every rms user
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rms_volt_c <= 16'h0000;
        end else begin
            o_rms_volt_c <= rms_d[2]; // R7
        end
    end

endmodule // mmg_config

`default_nettype wire

// [core/mmg_pkg.sv]
// package: register map, field layout and reset values of the mode/gain bank
package mmg_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] COMP_MODE_IDX = 16'he60e;
    localparam logic [15:0] CHAN_GAIN_IDX = 16'he60f;
    localparam int ADDR_W = 18;
    localparam logic [17:0] COMP_MODE_ADDR = {COMP_MODE_IDX, 2'b00};
    localparam logic [17:0] CHAN_GAIN_ADDR = {CHAN_GAIN_IDX, 2'b00};

    // mode register field positions
    localparam int PULSE_ONE_LSB = 0;
    localparam int PULSE_TWO_LSB = 3;
    localparam int PULSE_THREE_LSB = 6;
    localparam int ANGLE_LSB = 9;
    localparam int NOM_A_BIT = 11;
    localparam int NOM_B_BIT = 12;
    localparam int NOM_C_BIT = 13;
    localparam int FREQ_BIT = 14;

    // gain register field positions
    localparam int PHASE_I_GAIN_LSB = 0;
    localparam int NEUTRAL_I_GAIN_LSB = 3;
    localparam int PHASE_V_GAIN_LSB = 6;

    // reset values and writable masks
    localparam logic [15:0] COMP_MODE_RST = 16'h01ff;
    localparam logic [15:0] CHAN_GAIN_RST = 16'h0000;
    localparam logic [15:0] COMP_MODE_WMASK = 16'h7fff;
    localparam logic [15:0] CHAN_GAIN_WMASK_N = 16'h01ff;
    localparam logic [15:0] CHAN_GAIN_WMASK_NONEUT = 16'h01c7;

    // highest legal gain code (gain 16)
    localparam logic [2:0] GAIN_CODE_MAX = 3'h4;

    typedef enum logic [1:0] {
        MMG_ANGLE_V_TO_I = 2'h0,
        MMG_ANGLE_V_TO_V = 2'h1,
        MMG_ANGLE_I_TO_I = 2'h2,
        MMG_ANGLE_NONE = 2'h3
    } mmg_angle_e;

    // decoded configuration handed to the datapath
    typedef struct packed {
        logic [2:0] pulse_one_phase_sel;
        logic [2:0] pulse_two_phase_sel;
        logic [2:0] pulse_three_phase_sel;
        logic [3:0] angle_onehot;  // none, i-i, v-v, v-i
        logic [2:0] nominal_volt_use;  // c,b,a
        logic network_freq_select;
    } mmg_mode_s;

    typedef struct packed {
        logic [4:0] phase_current_gain;  // linear gain 1..16
        logic [4:0] neutral_current_gain;
        logic [4:0] phase_voltage_gain;
    } mmg_gain_s;

endpackage

// [dv/mmg_config_sva.sv]
// checker: port assertions of the mode and gain bank
`timescale 1ns/1ps
`default_nettype none
module mmg_config_sva (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [mmg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire mmg_pkg::mmg_mode_s o_mode,
    input wire mmg_pkg::mmg_gain_s o_gain
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // write decodes; w2 is write data two edges back
    wire logic wm = i_wr && i_addr == mmg_pkg::COMP_MODE_ADDR;
    wire logic wg = i_wr && i_addr == mmg_pkg::CHAN_GAIN_ADDR;
    logic [31:0] w1, w2;
    always_ff @(posedge i_clk) begin
        w1 <= i_wdata;
        w2 <= w1;
    end
    // reserved codes fall back to unity
    function automatic logic [4:0] gn(input logic [2:0] c);
        return (c > 3'h4) ? 5'h01 : 5'h01 << c;
    endfunction
    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero when idle");
    sel_one_a: assert property (wm |-> ##2 o_mode[16:14] == w2[2:0])
        else $error("pulse one select wrong");
    sel_two_a: assert property (wm |-> ##2 o_mode[13:11] == w2[5:3])
        else $error("pulse two select wrong");
    sel_three_a: assert property (wm |-> ##2 o_mode[10:8] == w2[8:6])
        else $error("pulse three select wrong");
    angle_sel_a: assert property (wm |-> ##2 o_mode[7:4] == 4'h1 << w2[10:9])
        else $error("angle select wrong");
    nom_use_a: assert property (wm |-> ##2 o_mode[3:1] == w2[13:11])
        else $error("nominal use wrong");
    freq_sel_a: assert property (wm |-> ##2 o_mode[0] == w2[14])
        else $error("frequency select wrong");
    gain_map_a: assert property (wg |-> ##2 o_gain == {gn(w2[2:0]),
        gn(w2[5:3]), gn(w2[8:6])}) else $error("gain decode wrong");
    rsv_rd_a: assert property (i_rd && i_addr == mmg_pkg::CHAN_GAIN_ADDR
        |=> o_rdata[31:9] == 23'h0) else $error("reserved gain bits set");
    cover property (wm);
    cover property (wg);
    cover property (i_rd ##1 o_rdata != 32'h0);
endmodule // mmg_config_sva
bind mmg_config mmg_config_sva u_sva (.i_clk, .i_sys_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_mode, .o_gain);
`default_nettype wire

// [dv/testbench.sv]
// testbench: register access and decoded outputs of the mode/gain bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [17:0] MA = mmg_pkg::COMP_MODE_ADDR;
    localparam logic [17:0] GA = mmg_pkg::CHAN_GAIN_ADDR;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [17:0] i_addr = 18'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] i_nominal_voltage_value = 16'h1234;
    logic [15:0] i_rms_volt_a = 16'h0a0a, i_rms_volt_b = 16'h0b0b;
    logic [15:0] i_rms_volt_c = 16'h0c0c, o_rms_volt_a, o_rms_volt_b, o_rms_volt_c;
    logic [31:0] o_rdata, q;
    mmg_pkg::mmg_mode_s o_mode;
    mmg_pkg::mmg_gain_s o_gain;
    int num_errors = 0;
    int cmp_count = 0;
    // 50 MHz clock
    initial forever #10 i_clk = ~i_clk;
    mmg_config dut (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .i_nominal_voltage_value, .i_rms_volt_a, .i_rms_volt_b, .i_rms_volt_c,
        .o_rdata, .o_mode, .o_gain, .o_rms_volt_a, .o_rms_volt_b, .o_rms_volt_c);
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // write ends once the decoded outputs have settled
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk) #1;
    endtask
    task automatic rd(input logic [17:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 q = o_rdata;
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // mode fields: pulse selects, angle codes, frequency, nominal use
    task automatic t_mode();
        logic [8:0] p;
        for (int i = 0; i < 4; i++) begin
            p = 9'h05b << i;
            wr(MA, {17'h0, i[0], 3'h0, i[1:0], p});
            chk(p[2:0], o_mode.pulse_one_phase_sel);
            chk(p[5:3], o_mode.pulse_two_phase_sel);
            chk(p[8:6], o_mode.pulse_three_phase_sel);
            chk(4'h1 << i, o_mode.angle_onehot);
            chk(i[0], o_mode.network_freq_select);
        end
        for (int k = 0; k < 3; k++) begin
            wr(MA, 32'h800 << k);
            chk(k == 0 ? 16'h1234 : 16'h0a0a, o_rms_volt_a);
            chk(k == 1 ? 16'h1234 : 16'h0b0b, o_rms_volt_b);
            chk(k == 2 ? 16'h1234 : 16'h0c0c, o_rms_volt_c);
            chk(3'h1 << k, o_mode.nominal_volt_use);
        end
        wr(MA, 32'hffffffff);
        rd(MA);
        chk(32'h7fff, q);
    endtask
    // every gain code on all three fields, then reserved bits
    task automatic t_gain();
        logic [4:0] e;
        for (int c = 0; c < 8; c++) begin
            e = (c > 4) ? 5'h01 : 5'h01 << c;
            wr(GA, {23'h0, c[2:0], c[2:0], c[2:0]});
            chk({e, e, e}, o_gain);
        end
        wr(GA, 32'hffffffff);
        rd(GA);
        chk(32'h01ff, q);
        wr(18'h0, 32'hffff);
        rd(18'h0);
        chk(32'h0, q);
        rd(GA);
        chk(32'h01ff, q);
    endtask
    // reset in mid-run brings registers and decodes back to defaults
    task automatic t_reset();
        wr(MA, 32'h7e00);
        wr(GA, 32'h0092);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk(32'h7, o_mode.pulse_one_phase_sel);
        chk(32'h1, o_gain.phase_current_gain);
        rd(MA);
        chk(32'h01ff, q);
        rd(GA);
        chk(32'h0, q);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(MA);
        chk(32'h01ff, q);
        rd(GA);
        chk(32'h0, q);
        t_mode();
        t_gain();
        t_reset();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
